// ### verilog/pci_irq_pkg.sv
package pci_irq_pkg;

  // ----------------------------------------------------------------
  // Register offsets, common to both bus sides except soft reset (decoded on PCI side only)
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFS_INT_STATUS = 8'h1c;
  localparam logic [7:0]  OFS_INT_MASK   = 8'h20;
  localparam logic [7:0]  OFS_PCI_STATUS = 8'h24;
  localparam logic [7:0]  OFS_SOFT_RESET = 8'h58;

  // ----------------------------------------------------------------
  // Implemented bits and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] INT_STATUS_VALID = 32'hffff_0fff;
  localparam logic [31:0] INT_MASK_VALID   = 32'hffff_0fff;
  localparam logic [31:0] PCI_STATUS_VALID = 32'hffff_07fe;
  localparam logic [31:0] USER_FIELD       = 32'hffff_0000;
  localparam logic [31:0] REG_RESET        = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Internal-side status bit positions
  // ----------------------------------------------------------------
  localparam int INT_DEV_IRQ      = 11;
  localparam int INT_EXT_SYSERR   = 10;
  localparam int INT_PARITY       = 9;
  localparam int INT_HOST_POWER   = 8;
  localparam int INT_SOFT_RESET   = 7;
  localparam int INT_IBUS_RD_ERR  = 6;
  localparam int INT_IBUS_WR_ERR  = 5;
  localparam int INT_FIFO_DISCARD = 4;
  localparam int INT_RD_TGT_ABORT = 3;
  localparam int INT_WR_TGT_ABORT = 2;
  localparam int INT_RD_MST_ABORT = 1;
  localparam int INT_WR_MST_ABORT = 0;

  // ----------------------------------------------------------------
  // PCI-side status bit positions
  // ----------------------------------------------------------------
  localparam int PCI_CPU_POWER    = 10;
  localparam int PCI_RESET_DONE   = 9;
  localparam int PCI_PARITY       = 8;
  localparam int PCI_SYSERR       = 7;
  localparam int PCI_MST_ABORT    = 6;
  localparam int PCI_TGT_ABORT    = 5;
  localparam int PCI_GAVE_ABORT   = 4;
  localparam int PCI_FIFO_DISCARD = 3;
  localparam int PCI_RETRY_TMO    = 2;
  localparam int PCI_IBUS_RD_ERR  = 1;

  // ----------------------------------------------------------------
  // Delayed-read discard limit in clocks
  // ----------------------------------------------------------------
  localparam int DISCARD_CLOCKS = 32768;

endpackage

// ### verilog/sticky_status.sv
module sticky_status #(
  parameter logic [31:0] VALID = 32'hffff_ffff
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic [31:0] setBits,
  input  wire logic        clrAll,
  output logic      [31:0] stat_r
);

  logic [31:0] stat_nxt;

  // Set wins over a clear in the same cycle
  assign stat_nxt = ((clrAll ? pci_irq_pkg::REG_RESET : stat_r) | setBits) & VALID;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stat_r <= pci_irq_pkg::REG_RESET;
    end else begin
      stat_r <= stat_nxt;
    end
  end

endmodule

// ### verilog/pci_bridge_interrupt_status_mask.sv
// Operation
// - Each mask bit gates its status bit; any passed bit raises CPU interrupt.
// - Mask 0 blocks, mask 1 passes; masks reset to 0.
// - Mask bits 31:16 and 11:0 read/write from both sides; 15:12 read zero.
// - Internal-bus read of internal status returns it, then clears all bits except those set in the read cycle.
// - PCI-side events set PCI status bits; unmasked ones interrupt the host.
// - PCI-bus read clears PCI status; internal-bus read leaves it.
// - Internal write of 1 to PCI status 31:16 sets bit, interrupts host.
// - PCI write of 1 to internal status 31:16 sets bit, interrupts CPU.
// - CPU power-state request sets PCI status bit 10.
// - CPU writes 1 to PCI status bit 9 when soft reset completes.
// - Host write to soft reset register sets internal status bit 7.
// - Host power request sets internal bit 8; CPU then reads power control.
// - PCI parity error sets PCI bit 8 and internal bit 9.
// - Driving system error sets PCI status bit 7.
// - Master abort bit 6, received target abort bit 5, signalled abort bit 4.
// - Target abort issued as target sets PCI status bit 4.
// - Unrepeated delayed read after 2^15 clocks: discard, set PCI 3, internal 4.
// - Retry timer expiry abandons access and sets PCI status bit 2.
// - Internal-bus read error as master sets PCI status bit 1.
// - Internal bits 6 and 5 record internal-bus read and write errors.
// - Internal bits 3,2 target aborts and 1,0 master aborts, read/write.
// - Host mode only: bit 11 device interrupt, bit 10 external system error.
module pci_bridge_interrupt_status_mask #(
  parameter int DISCARD_CLOCKS = pci_irq_pkg::DISCARD_CLOCKS
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        ibSel,
  input  wire logic        ibWr,
  input  wire logic [7:0]  ibAddr,
  input  wire logic [31:0] ibWdata,
  output logic      [31:0] ibRdata_r,
  output logic             ibRvalid_r,
  input  wire logic        pciSel,
  input  wire logic        pciWr,
  input  wire logic [7:0]  pciAddr,
  input  wire logic [31:0] pciWdata,
  output logic      [31:0] pciRdata_r,
  output logic             pciRvalid_r,
  input  wire logic [31:0] pciIrqMask,
  input  wire logic        hostMode,
  input  wire logic        deviceIrqSeen,
  input  wire logic        externalSyserrSeen,
  input  wire logic        parityErr,
  input  wire logic        hostPowerRequest,
  input  wire logic        cpuPowerRequest,
  input  wire logic        syserrDriven,
  input  wire logic        gotMasterAbort,
  input  wire logic        gotTargetAbort,
  input  wire logic        gaveTargetAbort,
  input  wire logic        ibusReadErr,
  input  wire logic        ibusWriteErr,
  input  wire logic        readTargetAbort,
  input  wire logic        writeTargetAbort,
  input  wire logic        readMasterAbort,
  input  wire logic        writeMasterAbort,
  input  wire logic        delayedReadHeld,
  input  wire logic        delayedReadRepeat,
  input  wire logic        retryExpired,
  output logic             fifoDiscard_r,
  output logic             retryAbandon_r,
  output logic             cpuIrq_r,
  output logic             pciIrq_r
);

  // ----------------------------------------------------------------
  // Address decoding
  // ----------------------------------------------------------------
  logic        ibRd;
  logic        ibWrt;
  logic        pciRd;
  logic        pciWrt;
  logic        ibRdIntStat;
  logic        pciRdPciStat;
  logic        ibWrMask;
  logic        pciWrMask;
  logic        ibWrPciStat;
  logic        pciWrIntStat;
  logic        pciWrSoftReset;

  assign ibRd           = ibSel && !ibWr;
  assign ibWrt          = ibSel && ibWr;
  assign pciRd          = pciSel && !pciWr;
  assign pciWrt         = pciSel && pciWr;
  assign ibRdIntStat    = ibRd && (ibAddr == pci_irq_pkg::OFS_INT_STATUS);
  assign pciRdPciStat   = pciRd && (pciAddr == pci_irq_pkg::OFS_PCI_STATUS);
  assign ibWrMask       = ibWrt && (ibAddr == pci_irq_pkg::OFS_INT_MASK);
  assign pciWrMask      = pciWrt && (pciAddr == pci_irq_pkg::OFS_INT_MASK);
  assign ibWrPciStat    = ibWrt && (ibAddr == pci_irq_pkg::OFS_PCI_STATUS);
  assign pciWrIntStat   = pciWrt && (pciAddr == pci_irq_pkg::OFS_INT_STATUS);
  assign pciWrSoftReset = pciWrt && (pciAddr == pci_irq_pkg::OFS_SOFT_RESET);

  // ----------------------------------------------------------------
  // Delayed-read discard timer
  // ----------------------------------------------------------------
  localparam logic [15:0] DISCARD_LAST = 16'(DISCARD_CLOCKS - 1);

  logic [15:0] discardCnt_r;
  logic [15:0] discardCnt_nxt;
  logic        discardHit;

  assign discardHit     = delayedReadHeld && !delayedReadRepeat && (discardCnt_r == DISCARD_LAST);
  assign discardCnt_nxt = (!delayedReadHeld || delayedReadRepeat || discardHit) ? 16'h0000
                        : 16'(discardCnt_r + 16'h0001);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      discardCnt_r   <= 16'h0000;
      fifoDiscard_r  <= 1'b0;
      retryAbandon_r <= 1'b0;
    end else begin
      discardCnt_r   <= discardCnt_nxt;
      fifoDiscard_r  <= discardHit;
      retryAbandon_r <= retryExpired;
    end
  end

  // ----------------------------------------------------------------
  // Internal-side status
  // ----------------------------------------------------------------
  logic [31:0] intSet;
  logic [31:0] intStat;

  always_comb begin
    intSet = pci_irq_pkg::REG_RESET;
    if (pciWrIntStat) begin
      intSet = pciWdata & pci_irq_pkg::USER_FIELD;
    end
    intSet[pci_irq_pkg::INT_DEV_IRQ]      = hostMode && deviceIrqSeen;
    intSet[pci_irq_pkg::INT_EXT_SYSERR]   = hostMode && externalSyserrSeen;
    intSet[pci_irq_pkg::INT_PARITY]       = parityErr;
    intSet[pci_irq_pkg::INT_HOST_POWER]   = hostPowerRequest;
    intSet[pci_irq_pkg::INT_SOFT_RESET]   = pciWrSoftReset;
    intSet[pci_irq_pkg::INT_IBUS_RD_ERR]  = ibusReadErr;
    intSet[pci_irq_pkg::INT_IBUS_WR_ERR]  = ibusWriteErr;
    intSet[pci_irq_pkg::INT_FIFO_DISCARD] = discardHit;
    intSet[pci_irq_pkg::INT_RD_TGT_ABORT] = readTargetAbort;
    intSet[pci_irq_pkg::INT_WR_TGT_ABORT] = writeTargetAbort;
    intSet[pci_irq_pkg::INT_RD_MST_ABORT] = readMasterAbort;
    intSet[pci_irq_pkg::INT_WR_MST_ABORT] = writeMasterAbort;
  end

  sticky_status #(
    .VALID (pci_irq_pkg::INT_STATUS_VALID)
  ) u_int_status (
    .core_clk (core_clk),
    .rstn     (rstn),
    .setBits  (intSet),
    .clrAll   (ibRdIntStat),
    .stat_r   (intStat)
  );

  // ----------------------------------------------------------------
  // PCI-side status
  // ----------------------------------------------------------------
  logic [31:0] pciSet;
  logic [31:0] pciStat;

  always_comb begin
    pciSet = pci_irq_pkg::REG_RESET;
    if (ibWrPciStat) begin
      pciSet = ibWdata & pci_irq_pkg::USER_FIELD;
      pciSet[pci_irq_pkg::PCI_RESET_DONE] = ibWdata[pci_irq_pkg::PCI_RESET_DONE];
    end
    pciSet[pci_irq_pkg::PCI_CPU_POWER]    = cpuPowerRequest;
    pciSet[pci_irq_pkg::PCI_PARITY]       = parityErr;
    pciSet[pci_irq_pkg::PCI_SYSERR]       = syserrDriven;
    pciSet[pci_irq_pkg::PCI_MST_ABORT]    = gotMasterAbort;
    pciSet[pci_irq_pkg::PCI_TGT_ABORT]    = gotTargetAbort;
    pciSet[pci_irq_pkg::PCI_GAVE_ABORT]   = gaveTargetAbort;
    pciSet[pci_irq_pkg::PCI_FIFO_DISCARD] = discardHit;
    pciSet[pci_irq_pkg::PCI_RETRY_TMO]    = retryExpired;
    pciSet[pci_irq_pkg::PCI_IBUS_RD_ERR]  = ibusReadErr;
  end

  sticky_status #(
    .VALID (pci_irq_pkg::PCI_STATUS_VALID)
  ) u_pci_status (
    .core_clk (core_clk),
    .rstn     (rstn),
    .setBits  (pciSet),
    .clrAll   (pciRdPciStat),
    .stat_r   (pciStat)
  );

  // ----------------------------------------------------------------
  // Internal-side mask
  // ----------------------------------------------------------------
  logic [31:0] intMask_r;
  logic [31:0] intMask_nxt;

  // An internal-bus write wins when both sides write in one cycle
  assign intMask_nxt = ibWrMask  ? (ibWdata & pci_irq_pkg::INT_MASK_VALID)
                     : pciWrMask ? (pciWdata & pci_irq_pkg::INT_MASK_VALID)
                     : intMask_r;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      intMask_r <= pci_irq_pkg::REG_RESET;
    end else begin
      intMask_r <= intMask_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read data and interrupts
  // ----------------------------------------------------------------
  logic [31:0] ibRdSel;
  logic [31:0] pciRdSel;

  assign ibRdSel = (ibAddr == pci_irq_pkg::OFS_INT_STATUS) ? intStat
                 : (ibAddr == pci_irq_pkg::OFS_INT_MASK)   ? intMask_r
                 : (ibAddr == pci_irq_pkg::OFS_PCI_STATUS) ? pciStat
                 : pci_irq_pkg::REG_RESET;

  assign pciRdSel = (pciAddr == pci_irq_pkg::OFS_INT_STATUS) ? intStat
                  : (pciAddr == pci_irq_pkg::OFS_INT_MASK)   ? intMask_r
                  : (pciAddr == pci_irq_pkg::OFS_PCI_STATUS) ? pciStat
                  : pci_irq_pkg::REG_RESET;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ibRdata_r   <= pci_irq_pkg::REG_RESET;
      ibRvalid_r  <= 1'b0;
      pciRdata_r  <= pci_irq_pkg::REG_RESET;
      pciRvalid_r <= 1'b0;
      cpuIrq_r    <= 1'b0;
      pciIrq_r    <= 1'b0;
    end else begin
      ibRdata_r   <= ibRd ? ibRdSel : ibRdata_r;
      ibRvalid_r  <= ibRd;
      pciRdata_r  <= pciRd ? pciRdSel : pciRdata_r;
      pciRvalid_r <= pciRd;
      cpuIrq_r    <= |(intStat & intMask_r);
      pciIrq_r    <= |(pciStat & pciIrqMask);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence intStatReadQuiet;
    ibRdIntStat && (intSet == 32'h0000_0000);
  endsequence

  sequence pciStatReadQuiet;
    pciRdPciStat && (pciSet == 32'h0000_0000);
  endsequence

  cpu_irq_gate_a: assert property (
    (intStat & intMask_r) != 32'h0000_0000 |=> cpuIrq_r)
    else $error("CPU interrupt missing for unmasked status");

  mask_blocks_a: assert property (
    intMask_r == 32'h0000_0000 |=> !cpuIrq_r)
    else $error("CPU interrupt raised while all masked");

  mask_hole_zero_a: assert property (
    intMask_r[15:12] == 4'h0)
    else $error("Mask bits 15 to 12 not zero");

  int_read_clear_a: assert property (
    intStatReadQuiet |=> (intStat == 32'h0000_0000) && (ibRdata_r == $past(intStat)))
    else $error("Internal status not returned and cleared");

  pci_event_irq_a: assert property (
    ((pciSet & pciIrqMask) != 32'h0000_0000) |=> ##1 pciIrq_r)
    else $error("PCI interrupt missing after unmasked event");

  pci_read_clear_a: assert property (
    pciStatReadQuiet |=> pciStat == 32'h0000_0000)
    else $error("PCI status not cleared by PCI read");

  pci_keep_a: assert property (
    !pciRdPciStat |=> ($past(pciStat) & ~pciStat) == 32'h0000_0000)
    else $error("PCI status lost bits without PCI read");

  host_doorbell_a: assert property (
    ibWrPciStat |=> (pciStat & ($past(ibWdata) & 32'hffff_0000)) == ($past(ibWdata) & 32'hffff_0000))
    else $error("Host doorbell bit not set");

  cpu_doorbell_a: assert property (
    pciWrIntStat |=> (intStat & ($past(pciWdata) & 32'hffff_0000)) == ($past(pciWdata) & 32'hffff_0000))
    else $error("CPU doorbell bit not set");

  parity_both_a: assert property (
    parityErr |=> intStat[9] && pciStat[8])
    else $error("Parity error not flagged on both sides");

  discard_limit_a: assert property (
    delayedReadHeld && !delayedReadRepeat && (discardCnt_r == DISCARD_LAST)
    |=> fifoDiscard_r && intStat[4] && pciStat[3] && (discardCnt_r == 16'h0000))
    else $error("Delayed read not discarded at limit");

  soft_reset_flag_a: assert property (
    pciWrSoftReset |=> intStat[7])
    else $error("Soft reset request not flagged");

  host_power_flag_a: assert property (
    hostPowerRequest |=> intStat[8])
    else $error("Host power request not flagged");

  cpu_power_flag_a: assert property (
    cpuPowerRequest |=> pciStat[10])
    else $error("CPU power request not flagged");

  reset_done_flag_a: assert property (
    ibWrPciStat && ibWdata[9] |=> pciStat[9])
    else $error("Soft reset done not flagged");

  syserr_flag_a: assert property (
    syserrDriven |=> pciStat[7])
    else $error("Driven system error not flagged");

  got_master_abort_a: assert property (
    gotMasterAbort |=> pciStat[6])
    else $error("Received master abort not flagged");

  got_target_abort_a: assert property (
    gotTargetAbort |=> pciStat[5])
    else $error("Received target abort not flagged");

  gave_abort_flag_a: assert property (
    gaveTargetAbort |=> pciStat[4])
    else $error("Signalled target abort not flagged");

  retry_flag_a: assert property (
    retryExpired |=> pciStat[2] && retryAbandon_r)
    else $error("Retry expiry not flagged or not abandoned");

  ibus_rd_err_a: assert property (
    ibusReadErr |=> pciStat[1] && intStat[6])
    else $error("Internal bus read error not flagged on both sides");

  ibus_wr_err_a: assert property (
    ibusWriteErr |=> intStat[5])
    else $error("Internal bus write error not flagged");

  pci_abort_bits_a: assert property (
    readTargetAbort || writeTargetAbort || readMasterAbort || writeMasterAbort |=>
    (~intStat[3:0] & $past({readTargetAbort, writeTargetAbort, readMasterAbort,
    writeMasterAbort})) == 4'h0)
    else $error("PCI abort bits not set");

  device_mode_gate_a: assert property (
    !hostMode && ibRdIntStat |=> intStat[11:10] == 2'b00)
    else $error("Host-mode-only bits set in device mode");

  mask_write_a: assert property (
    ibWrMask |=> intMask_r == ($past(ibWdata) & 32'hffff_0fff))
    else $error("Mask write from internal bus not taken");

  reserved_zero_a: assert property (
    (intStat[15:12] == 4'h0) && (pciStat[15:11] == 5'h00) && !pciStat[0])
    else $error("Reserved status bits not zero");

endmodule

// ### verification/bridge_far_side.sv
module bridge_far_side (
  input  wire logic        core_clk,
  output logic             ibSel,
  output logic             ibWr,
  output logic      [7:0]  ibAddr,
  output logic      [31:0] ibWdata,
  input  wire logic [31:0] ibRdata_r,
  input  wire logic        ibRvalid_r,
  output logic             pciSel,
  output logic             pciWr,
  output logic      [7:0]  pciAddr,
  output logic      [31:0] pciWdata,
  input  wire logic [31:0] pciRdata_r,
  input  wire logic        pciRvalid_r
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {ibSel, ibWr, ibAddr, ibWdata} = '0;
    {pciSel, pciWr, pciAddr, pciWdata} = '0;
  end

  // ----------------------------------------------------------------
  // Bus access, one strobe cycle; released lines show inverted values
  // ----------------------------------------------------------------
  task automatic acc(input logic pci, input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q, output logic v);
    @(negedge core_clk);
    if (pci) {pciSel, pciWr, pciAddr, pciWdata} = {1'b1, wr, a, d};
    else {ibSel, ibWr, ibAddr, ibWdata} = {1'b1, wr, a, d};
    @(negedge core_clk);
    if (pci) begin
      {pciSel, pciAddr, pciWdata} = {1'b0, ~a, ~d};
      q = pciRdata_r;
      v = pciRvalid_r;
    end else begin
      {ibSel, ibAddr, ibWdata} = {1'b0, ~a, ~d};
      q = ibRdata_r;
      v = ibRvalid_r;
    end
  endtask

  // CPU reports that the requested soft reset has finished
  task automatic resetDone();
    logic [31:0] q;
    logic        v;
    acc(1'b0, 1'b1, pci_irq_pkg::OFS_PCI_STATUS, 32'h0000_0200, q, v);
  endtask
endmodule

// ### verification/pci_bridge_interrupt_status_mask_tb_top.sv
module pci_bridge_interrupt_status_mask_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [15:0] ev = '0;
  logic        hostMode = 1'b1;
  logic [31:0] pciIrqMask = '0;
  logic        held = 1'b0;
  logic        rep = 1'b0;
  logic        ibSel, ibWr, pciSel, pciWr, ibRvalid_r, pciRvalid_r;
  logic [7:0]  ibAddr, pciAddr;
  logic [31:0] ibWdata, pciWdata, ibRdata_r, pciRdata_r;
  logic        fifoDiscard_r, retryAbandon_r, cpuIrq_r, pciIrq_r;
  int          fail_count = 0;
  int          n_checks = 0;

  localparam logic [31:0] INT_EXP [16] = '{32'h800, 32'h400, 32'h200, 32'h100, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h40, 32'h20, 32'h8, 32'h4, 32'h2, 32'h1, 32'h0};
  localparam logic [31:0] PCI_EXP [16] = '{32'h0, 32'h0, 32'h100, 32'h0, 32'h400, 32'h80,
    32'h40, 32'h20, 32'h10, 32'h2, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h4};

  always #12.5 core_clk = ~core_clk;

  pci_bridge_interrupt_status_mask #(.DISCARD_CLOCKS(8)) dut_u (
    .core_clk(core_clk), .rstn(rstn), .ibSel(ibSel), .ibWr(ibWr), .ibAddr(ibAddr),
    .ibWdata(ibWdata), .ibRdata_r(ibRdata_r), .ibRvalid_r(ibRvalid_r), .pciSel(pciSel),
    .pciWr(pciWr), .pciAddr(pciAddr), .pciWdata(pciWdata), .pciRdata_r(pciRdata_r),
    .pciRvalid_r(pciRvalid_r), .pciIrqMask(pciIrqMask), .hostMode(hostMode),
    .deviceIrqSeen(ev[0]), .externalSyserrSeen(ev[1]), .parityErr(ev[2]),
    .hostPowerRequest(ev[3]), .cpuPowerRequest(ev[4]), .syserrDriven(ev[5]),
    .gotMasterAbort(ev[6]), .gotTargetAbort(ev[7]), .gaveTargetAbort(ev[8]),
    .ibusReadErr(ev[9]), .ibusWriteErr(ev[10]), .readTargetAbort(ev[11]),
    .writeTargetAbort(ev[12]), .readMasterAbort(ev[13]), .writeMasterAbort(ev[14]),
    .retryExpired(ev[15]), .delayedReadHeld(held), .delayedReadRepeat(rep),
    .fifoDiscard_r(fifoDiscard_r), .retryAbandon_r(retryAbandon_r), .cpuIrq_r(cpuIrq_r),
    .pciIrq_r(pciIrq_r));

  bridge_far_side mdl_u (
    .core_clk(core_clk), .ibSel(ibSel), .ibWr(ibWr), .ibAddr(ibAddr), .ibWdata(ibWdata),
    .ibRdata_r(ibRdata_r), .ibRvalid_r(ibRvalid_r), .pciSel(pciSel), .pciWr(pciWr),
    .pciAddr(pciAddr), .pciWdata(pciWdata), .pciRdata_r(pciRdata_r),
    .pciRvalid_r(pciRvalid_r));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  task automatic rd(input logic p, input logic [7:0] a, input logic [31:0] exp,
                    input string nm);
    logic [31:0] q;
    logic        v;
    mdl_u.acc(p, 1'b0, a, 32'h0, q, v);
    chk({nm, " valid"}, {31'h0, v}, 32'h1);
    chk(nm, q, exp);
  endtask

  task automatic wr(input logic p, input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        v;
    mdl_u.acc(p, 1'b1, a, d, q, v);
  endtask

  task automatic pulse(input logic [15:0] m);
    @(negedge core_clk);
    ev = m;
    @(negedge core_clk);
    ev = '0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(1'b0, pci_irq_pkg::OFS_INT_MASK, 32'h0, "mask reset");
    rd(1'b0, pci_irq_pkg::OFS_PCI_STATUS, 32'h0, "pci status reset");
    rd(1'b1, pci_irq_pkg::OFS_INT_STATUS, 32'h0, "int status reset");
    chk("irqs reset", {30'h0, cpuIrq_r, pciIrq_r}, 32'h0);
  endtask

  task automatic t_mask();
    wr(1'b0, pci_irq_pkg::OFS_INT_MASK, 32'hffff_ffff);
    rd(1'b1, pci_irq_pkg::OFS_INT_MASK, 32'hffff_0fff, "mask from pci");
    wr(1'b1, pci_irq_pkg::OFS_INT_MASK, 32'h0001_0200);
    rd(1'b0, pci_irq_pkg::OFS_INT_MASK, 32'h0001_0200, "mask from ibus");
  endtask

  task automatic t_events();
    for (int i = 0; i < 16; i++) begin
      pulse(16'h1 << i);
      if (i == 15) chk("retry abandon", {31'h0, retryAbandon_r}, 32'h1);
      rd(1'b0, pci_irq_pkg::OFS_INT_STATUS, INT_EXP[i], "int event");
      rd(1'b1, pci_irq_pkg::OFS_PCI_STATUS, PCI_EXP[i], "pci event");
    end
    wr(1'b1, pci_irq_pkg::OFS_SOFT_RESET, 32'h1);
    rd(1'b0, pci_irq_pkg::OFS_INT_STATUS, 32'h80, "soft reset request");
    hostMode = 1'b0;
    pulse(16'h0003);
    rd(1'b0, pci_irq_pkg::OFS_INT_STATUS, 32'h0, "device mode");
  endtask

  task automatic t_irq();
    pulse(16'h0004);
    @(negedge core_clk);
    chk("cpu irq unmasked", {31'h0, cpuIrq_r}, 32'h1);
    chk("pci irq masked", {31'h0, pciIrq_r}, 32'h0);
    pciIrqMask = 32'h100;
    repeat (2) @(negedge core_clk);
    chk("pci irq unmasked", {31'h0, pciIrq_r}, 32'h1);
    rd(1'b0, pci_irq_pkg::OFS_INT_STATUS, 32'h200, "int clear read");
    @(negedge core_clk);
    chk("cpu irq cleared", {31'h0, cpuIrq_r}, 32'h0);
    rd(1'b0, pci_irq_pkg::OFS_PCI_STATUS, 32'h100, "pci ibus read");
    rd(1'b1, pci_irq_pkg::OFS_PCI_STATUS, 32'h100, "pci host read");
    rd(1'b1, pci_irq_pkg::OFS_PCI_STATUS, 32'h0, "pci after clear");
    wr(1'b0, pci_irq_pkg::OFS_INT_MASK, 32'h0);
    pulse(16'h0004);
    repeat (2) @(negedge core_clk);
    chk("cpu irq blocked", {31'h0, cpuIrq_r}, 32'h0);
    rd(1'b0, pci_irq_pkg::OFS_INT_STATUS, 32'h200, "blocked status");
  endtask

  task automatic t_doorbell();
    pciIrqMask = 32'h0001_0000;
    wr(1'b0, pci_irq_pkg::OFS_PCI_STATUS, 32'h0001_f001);
    mdl_u.resetDone();
    @(negedge core_clk);
    chk("host doorbell irq", {31'h0, pciIrq_r}, 32'h1);
    rd(1'b1, pci_irq_pkg::OFS_PCI_STATUS, 32'h0001_0300, "host doorbell");
    pciIrqMask = 32'h0;
    wr(1'b0, pci_irq_pkg::OFS_INT_MASK, 32'h8000_0000);
    wr(1'b1, pci_irq_pkg::OFS_INT_STATUS, 32'h8000_f000);
    @(negedge core_clk);
    chk("cpu doorbell irq", {31'h0, cpuIrq_r}, 32'h1);
    rd(1'b0, pci_irq_pkg::OFS_INT_STATUS, 32'h8000_0000, "cpu doorbell");
    rd(1'b0, 8'h40, 32'h0, "unmapped");
  endtask

  task automatic t_discard();
    int n;
    n = 0;
    @(negedge core_clk);
    held = 1'b1;
    repeat (5) @(negedge core_clk);
    rep = 1'b1;
    @(negedge core_clk);
    rep = 1'b0;
    while (n < 20 && fifoDiscard_r !== 1'b1) begin
      @(negedge core_clk);
      n++;
    end
    chk("discard delay", n, 32'd8);
    held = 1'b0;
    @(negedge core_clk);
    chk("discard pulse", {31'h0, fifoDiscard_r}, 32'h0);
    rd(1'b0, pci_irq_pkg::OFS_INT_STATUS, 32'h10, "int discard");
    rd(1'b1, pci_irq_pkg::OFS_PCI_STATUS, 32'h8, "pci discard");
  endtask

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    end_sim();
  end

  initial begin
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    rstn = 1'b1;
    t_reset();
    t_mask();
    t_events();
    t_irq();
    t_doorbell();
    t_discard();
    end_sim();
  end
endmodule
